// >>> verilog/fkp_flash_guard.sv
`include "fkp_defines.svh"
module fkp_flash_guard #(
  parameter int DBG_WINDOW_CYCLES = `FKP_DBG_WINDOW_CYCLES,
  parameter int LO_W = 32,
  parameter int HI_W = 16
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic flash_done,
  output logic flash_prog_start,
  output logic flash_erase_start,
  output logic flash_mass_erase,
  output logic [31:0] flash_addr,
  output logic debug_port_enable,
  output logic violation_irq
);

  localparam int CW = $clog2(DBG_WINDOW_CYCLES + 1);
  fkp_pkg::fkp_state_e state_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] addr_ff;
  logic [31:0] flash_addr_ff;
  logic prog_start_ff;
  logic erase_start_ff;
  logic mass_out_ff;
  logic pgm_unl_ff;
  logic ers_unl_ff;
  logic lock_ff;
  logic key_ff;
  logic [LO_W-1:0] prot_lo_ff;
  logic [HI_W-1:0] prot_hi_ff;
  logic ctl_unl_ff;
  logic mass_ff;
  logic viol_ff;
  logic ie_ff;
  logic irq_ff;
  logic dbg_en_ff;
  logic [CW-1:0] dbg_cnt_ff;
  logic access;
  logic wr;
  logic rd;
  logic [31:0] bmask;
  logic [63:0] map_all;
  logic [5:0] kb;
  logic prot_hit;
  logic prot_any;
  logic erase_prot;
  logic launch_ok;
  logic commit_ok;
  logic prog_go;
  logic erase_go;
  logic viol_evt;
  logic busy;
  logic window_done;
  logic mapped;
  logic [31:0] rdata;
  assign access = psel & penable & ~pready_ff;
  assign wr = access & pwrite;
  assign rd = access & ~pwrite;
  assign bmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
  assign busy = state_ff != fkp_pkg::FKP_IDLE;
  assign window_done = dbg_cnt_ff == CW'(DBG_WINDOW_CYCLES);
  assign map_all = {{(64 - LO_W - HI_W){1'b0}}, prot_hi_ff, prot_lo_ff};
  assign kb = addr_ff[`FKP_KB_LSB +: 6];
  assign prot_hit = key_ff & map_all[kb];
  assign prot_any = key_ff & (|map_all);
  assign erase_prot = mass_ff ? prot_any : prot_hit;
  assign launch_ok = wr & (paddr == `FKP_ADDR_PGM_LAUNCH) & (pwdata == `FKP_KEY_PGM_LAUNCH) & pgm_unl_ff & ~busy;
  assign commit_ok = wr & (paddr == `FKP_ADDR_ERS_COMMIT) & (pwdata == `FKP_KEY_ERS_COMMIT) & ers_unl_ff & ~busy;
  assign prog_go = launch_ok & ~prot_hit;
  assign erase_go = commit_ok & ~erase_prot;
  assign viol_evt = (launch_ok & prot_hit) | (commit_ok & erase_prot);
  // Address decode and read mux
  always_comb begin
    mapped = 1'b1;
    rdata = `FKP_RST_WORD;
    if (paddr == `FKP_ADDR_TARGET) begin
      rdata = addr_ff;
    end else if (paddr == `FKP_ADDR_PGM_UNLOCK) begin
      rdata = {31'h0000_0000, pgm_unl_ff};
    end else if (paddr == `FKP_ADDR_PGM_LAUNCH) begin
      rdata = `FKP_RST_WORD;
    end else if (paddr == `FKP_ADDR_ERS_UNLOCK) begin
      rdata = {31'h0000_0000, ers_unl_ff};
    end else if (paddr == `FKP_ADDR_ERS_COMMIT) begin
      rdata = `FKP_RST_WORD;
    end else if (paddr == `FKP_ADDR_DBG_LOCK) begin
      rdata = {31'h0000_0000, lock_ff};
    end else if (paddr == `FKP_ADDR_PROT_KEY) begin
      rdata = {31'h0000_0000, key_ff};
    end else if (paddr == `FKP_ADDR_PROT_LO) begin
      rdata = 32'(prot_lo_ff);
    end else if (paddr == `FKP_ADDR_PROT_HI) begin
      rdata = 32'(prot_hi_ff);
    end else if (paddr == `FKP_ADDR_CTL_UNLOCK) begin
      rdata = {31'h0000_0000, ctl_unl_ff};
    end else if (paddr == `FKP_ADDR_CTL_OP) begin
      rdata[`FKP_BIT_MASS_SEL] = mass_ff;
    end else if (paddr == `FKP_ADDR_VIOL_STAT) begin
      rdata[`FKP_BIT_VIOL] = viol_ff;
      rdata[`FKP_BIT_VIOL_IE] = ie_ff;
    end else if (paddr == `FKP_ADDR_BUSY_STAT) begin
      rdata[`FKP_BIT_BUSY] = busy;
    end else begin
      mapped = 1'b0;
    end
  end

  // Bus answer, one wait state
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= `FKP_RST_WORD;
    end else if (ce) begin
      pready_ff <= access;
      pslverr_ff <= access & ~mapped;
      prdata_ff <= (rd & mapped) ? rdata : `FKP_RST_WORD;
    end
  end

  // Target address
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      addr_ff <= `FKP_RST_WORD;
    end else if (ce && wr && paddr == `FKP_ADDR_TARGET && !busy) begin
      addr_ff <= (addr_ff & ~bmask) | (pwdata & bmask);
    end
  end

  // Program and erase unlock keys
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pgm_unl_ff <= 1'b0;
      ers_unl_ff <= 1'b0;
    end else if (ce) begin
      if (wr && paddr == `FKP_ADDR_PGM_UNLOCK) begin
        pgm_unl_ff <= pwdata == `FKP_KEY_PGM_UNLOCK;
      end else if (prog_go) begin
        pgm_unl_ff <= 1'b0;
      end
      // Set by key, cleared by start or other value
      if (wr && paddr == `FKP_ADDR_ERS_UNLOCK) begin
        ers_unl_ff <= pwdata == `FKP_KEY_ERS_UNLOCK;
      end else if (erase_go) begin
        ers_unl_ff <= 1'b0;
      end
    end
  end

  // Operation sequencer
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= fkp_pkg::FKP_IDLE;
    end else if (ce) begin
      case (state_ff)
        fkp_pkg::FKP_IDLE: begin
          if (prog_go) begin
            state_ff <= fkp_pkg::FKP_PROG;
          end else if (erase_go) begin
            state_ff <= fkp_pkg::FKP_ERASE;
          end
        end
        fkp_pkg::FKP_PROG, fkp_pkg::FKP_ERASE: begin
          if (flash_done) begin
            state_ff <= fkp_pkg::FKP_IDLE;
          end
        end
        default: begin
          state_ff <= fkp_pkg::FKP_IDLE;
        end
      endcase
    end
  end

  // Start pulses to the array
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prog_start_ff <= 1'b0;
      erase_start_ff <= 1'b0;
      mass_out_ff <= 1'b0;
      flash_addr_ff <= `FKP_RST_WORD;
    end else if (ce) begin
      prog_start_ff <= prog_go;
      erase_start_ff <= erase_go;
      if (prog_go || erase_go) begin
        mass_out_ff <= erase_go & mass_ff;
        flash_addr_ff <= addr_ff;
      end
    end
  end

  // Debug lockout and reset window
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lock_ff <= 1'b0;
      dbg_cnt_ff <= '0;
      dbg_en_ff <= 1'b0;
    end else if (ce) begin
      if (wr && paddr == `FKP_ADDR_DBG_LOCK) begin
        lock_ff <= pwdata == `FKP_KEY_DBG_LOCK;
      end
      if (!window_done) begin
        dbg_cnt_ff <= dbg_cnt_ff + CW'(1);
      end
      dbg_en_ff <= window_done & ~lock_ff;
    end
  end

  // Write protection key and bitmaps
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      key_ff <= 1'b0;
      prot_lo_ff <= '0;
      prot_hi_ff <= '0;
    end else if (ce) begin
      if (wr && paddr == `FKP_ADDR_PROT_KEY && pwdata == `FKP_KEY_PROT) begin
        key_ff <= 1'b1;
      end
      if (wr && !key_ff && paddr == `FKP_ADDR_PROT_LO) begin
        prot_lo_ff <= (prot_lo_ff & bmask[LO_W-1:0]) ^ prot_lo_ff ^ (pwdata[LO_W-1:0] & bmask[LO_W-1:0]);
      end
      if (wr && !key_ff && paddr == `FKP_ADDR_PROT_HI) begin
        prot_hi_ff <= (prot_hi_ff & ~bmask[HI_W-1:0]) | (pwdata[HI_W-1:0] & bmask[HI_W-1:0]);
      end
    end
  end

  // Control operation unlock and mass erase select
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctl_unl_ff <= 1'b0;
      mass_ff <= 1'b0;
    end else if (ce) begin
      if (wr && paddr == `FKP_ADDR_CTL_UNLOCK) begin
        ctl_unl_ff <= pwdata == `FKP_KEY_CTL_UNLOCK;
      end else if (wr && paddr == `FKP_ADDR_CTL_OP && pstrb[2]) begin
        ctl_unl_ff <= 1'b0;
      end
      if (wr && paddr == `FKP_ADDR_CTL_OP && pstrb[2] && ctl_unl_ff) begin
        mass_ff <= pwdata[`FKP_BIT_MASS_SEL];
      end
    end
  end

  // Violation flag and interrupt
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      viol_ff <= 1'b0;
      ie_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else if (ce) begin
      if (viol_evt) begin
        viol_ff <= 1'b1;
      end else if (wr && paddr == `FKP_ADDR_VIOL_STAT && pstrb[3] && pwdata[`FKP_BIT_VIOL]) begin
        viol_ff <= 1'b0;
      end
      if (wr && paddr == `FKP_ADDR_VIOL_STAT && pstrb[2]) begin
        ie_ff <= pwdata[`FKP_BIT_VIOL_IE];
      end
      irq_ff <= viol_ff & ie_ff;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign flash_prog_start = prog_start_ff;
  assign flash_erase_start = erase_start_ff;
  assign flash_mass_erase = mass_out_ff;
  assign flash_addr = flash_addr_ff;
  assign debug_port_enable = dbg_en_ff;
  assign violation_irq = irq_ff;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  sequence s_unlocked_launch;
    ce && launch_ok && !prot_hit;
  endsequence
  sequence s_started_prog;
    prog_start_ff && state_ff == fkp_pkg::FKP_PROG;
  endsequence
  prog_start_a: assert property (s_unlocked_launch |=> s_started_prog)
    else $error("program did not start after launch key");
  launch_read_a: assert property (ce && rd && paddr == `FKP_ADDR_PGM_LAUNCH |=> prdata_ff == 32'h0000_0000)
    else $error("launch register read not zero");
  erase_unl_a: assert property (erase_start_ff |-> $past(ers_unl_ff))
    else $error("erase started without unlock");
  ers_bit_a: assert property (ce && erase_go |=> !ers_unl_ff)
    else $error("erase unlock bit not cleared on start");
  commit_read_a: assert property (ce && rd && paddr == `FKP_ADDR_ERS_COMMIT |=> prdata_ff == 32'h0000_0000)
    else $error("commit register read not zero");
  dbg_off_a: assert property (ce && lock_ff |=> !dbg_en_ff)
    else $error("debug port enabled while locked out");
  lock_bit_a: assert property (ce && wr && paddr == `FKP_ADDR_DBG_LOCK |=> lock_ff == ($past(pwdata) == `FKP_KEY_DBG_LOCK))
    else $error("lockout bit wrong after write");
  window_a: assert property (!window_done |-> !dbg_en_ff)
    else $error("debug enabled inside reset window");
  key_sticky_a: assert property (key_ff |=> key_ff)
    else $error("protection key bit cleared");
  map_lock_a: assert property (key_ff |=> $stable(prot_lo_ff) && $stable(prot_hi_ff))
    else $error("bitmap changed after activation");
  prot_block_a: assert property (ce && launch_ok && prot_hit |=> !prog_start_ff ##0 viol_ff)
    else $error("protected program not blocked");
  relock_a: assert property (ce && wr && paddr == `FKP_ADDR_CTL_OP && pstrb[2] |=> !ctl_unl_ff)
    else $error("control unlock survived byte two write");
  mass_lock_a: assert property (ce && wr && paddr == `FKP_ADDR_CTL_OP && !ctl_unl_ff |=> $stable(mass_ff))
    else $error("mass select changed while locked");
  no_unl_a: assert property (ce && wr && paddr == `FKP_ADDR_PGM_LAUNCH && !pgm_unl_ff |=> !prog_start_ff)
    else $error("program started without unlock");
endmodule // fkp_flash_guard

// >>> pkg/fkp_defines.svh
`ifndef FKP_DEFINES_SVH
`define FKP_DEFINES_SVH

// Register byte addresses
`define FKP_ADDR_TARGET 32'h5002_1000
`define FKP_ADDR_PGM_UNLOCK 32'h5002_1010
`define FKP_ADDR_PGM_LAUNCH 32'h5002_1014
`define FKP_ADDR_ERS_UNLOCK 32'h5002_1018
`define FKP_ADDR_ERS_COMMIT 32'h5002_101C
`define FKP_ADDR_DBG_LOCK 32'h5002_1020
`define FKP_ADDR_PROT_KEY 32'h5002_1024
`define FKP_ADDR_PROT_LO 32'h5002_1028
`define FKP_ADDR_PROT_HI 32'h5002_102C
`define FKP_ADDR_CTL_UNLOCK 32'h5002_1030
`define FKP_ADDR_CTL_OP 32'h5002_1034
`define FKP_ADDR_VIOL_STAT 32'h5002_1038
`define FKP_ADDR_BUSY_STAT 32'h5002_1040

// Key values
`define FKP_KEY_PGM_UNLOCK 32'h5555_5555
`define FKP_KEY_PGM_LAUNCH 32'h0AAA_AAAA
`define FKP_KEY_ERS_UNLOCK 32'h6666_6666
`define FKP_KEY_ERS_COMMIT 32'h9999_9999
`define FKP_KEY_DBG_LOCK 32'hF2E1_1047
`define FKP_KEY_PROT 32'h1210_0511
`define FKP_KEY_CTL_UNLOCK 32'hACDC_1972

// Field positions
`define FKP_BIT_MASS_SEL 16
`define FKP_BIT_VIOL 24
`define FKP_BIT_VIOL_IE 23
`define FKP_BIT_BUSY 8
`define FKP_KB_LSB 10

// Reset values and timing
`define FKP_RST_WORD 32'h0000_0000
`define FKP_DBG_WINDOW_CYCLES 8192

`endif

// >>> pkg/fkp_pkg.sv
package fkp_pkg;
  typedef enum logic [1:0] {
    FKP_IDLE,
    FKP_PROG,
    FKP_ERASE
  } fkp_state_e;
endpackage

// >>> verification/fkp_testbench.sv
`include "fkp_defines.svh"

module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, nrst, ce, psel, penable, pwrite, flash_done, pready, pslverr, slv;
  logic flash_prog_start, flash_erase_start, flash_mass_erase, debug_port_enable, violation_irq;
  logic [31:0] paddr, pwdata, prdata, flash_addr, rdv;
  logic [3:0] pstrb;
  int err_count, total_checks, n_prog, n_erase, b;

  fkp_flash_guard #(.DBG_WINDOW_CYCLES(16)) dut (.clk(clk), .nrst(nrst), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .flash_done(flash_done), .flash_prog_start(flash_prog_start),
    .flash_erase_start(flash_erase_start), .flash_mass_erase(flash_mass_erase), .flash_addr(flash_addr),
    .debug_port_enable(debug_port_enable), .violation_irq(violation_irq));

  initial clk = 1'b0;
  always #50 clk = ~clk;

  // Start pulses counted at each rising clock edge
  always @(posedge clk) begin
    if (flash_prog_start === 1'b1) n_prog++;
    if (flash_erase_start === 1'b1) n_erase++;
  end

  task summarize;
    if (err_count == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task apb(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1);
    check("pready wait", n, 32'h0000_0002);
    rdv = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hF);
  endtask

  task rchk(input string what, input logic [31:0] a, input logic [31:0] mask, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000, 4'hF);
    check(what, rdv & mask, exp);
  endtask

  task do_reset;
    nrst <= 1'b0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
  endtask

  task op_done;
    flash_done <= 1'b1;
    @(posedge clk);
    flash_done <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  task t_window;
    int n;
    repeat (11) @(posedge clk);
    check("dbg early", {31'b0, debug_port_enable}, 32'h0000_0000);
    ce <= 1'b0;
    repeat (10) @(posedge clk);
    check("dbg frozen", {31'b0, debug_port_enable}, 32'h0000_0000);
    ce <= 1'b1;
    n = 0;
    while (debug_port_enable !== 1'b1 && n < 10) begin
      @(posedge clk);
      n++;
    end
    check("dbg late", {31'b0, debug_port_enable}, 32'h0000_0001);
  endtask

  task t_regs;
    logic [31:0] addrs [8];
    addrs = '{`FKP_ADDR_ERS_UNLOCK, `FKP_ADDR_ERS_COMMIT, `FKP_ADDR_DBG_LOCK, `FKP_ADDR_PROT_KEY,
      `FKP_ADDR_PROT_LO, `FKP_ADDR_PROT_HI, `FKP_ADDR_CTL_UNLOCK, `FKP_ADDR_PGM_LAUNCH};
    foreach (addrs[i]) rchk("reset value", addrs[i], 32'hFFFF_FFFF, 32'h0000_0000);
    rchk("unmapped data", 32'h5002_103C, 32'hFFFF_FFFF, 32'h0000_0000);
    check("unmapped err", {31'b0, slv}, 32'h0000_0001);
  endtask

  task t_debug;
    wr(`FKP_ADDR_DBG_LOCK, `FKP_KEY_DBG_LOCK);
    rchk("lock bit", `FKP_ADDR_DBG_LOCK, 32'hFFFF_FFFF, 32'h0000_0001);
    check("dbg off", {31'b0, debug_port_enable}, 32'h0000_0000);
    wr(`FKP_ADDR_DBG_LOCK, 32'hF2E1_1046);
    rchk("lock clr", `FKP_ADDR_DBG_LOCK, 32'hFFFF_FFFF, 32'h0000_0000);
    check("dbg on", {31'b0, debug_port_enable}, 32'h0000_0001);
    wr(`FKP_ADDR_DBG_LOCK, `FKP_KEY_DBG_LOCK);
  endtask

  task t_program;
    b = n_prog;
    wr(`FKP_ADDR_TARGET, 32'h0000_0C00);
    wr(`FKP_ADDR_PGM_LAUNCH, `FKP_KEY_PGM_LAUNCH);
    check("bare launch", n_prog - b, 32'h0000_0000);
    wr(`FKP_ADDR_PGM_UNLOCK, `FKP_KEY_PGM_UNLOCK);
    wr(`FKP_ADDR_PGM_LAUNCH, `FKP_KEY_PGM_LAUNCH);
    check("prog start", n_prog - b, 32'h0000_0001);
    check("prog addr", flash_addr, 32'h0000_0C00);
    rchk("busy", `FKP_ADDR_BUSY_STAT, 32'h0000_0100, 32'h0000_0100);
    rchk("launch read", `FKP_ADDR_PGM_LAUNCH, 32'hFFFF_FFFF, 32'h0000_0000);
    op_done();
    rchk("idle", `FKP_ADDR_BUSY_STAT, 32'h0000_0100, 32'h0000_0000);
    wr(`FKP_ADDR_DBG_LOCK, 32'h0000_0000);
  endtask

  task erase(input logic [31:0] a);
    wr(`FKP_ADDR_TARGET, a);
    wr(`FKP_ADDR_ERS_UNLOCK, `FKP_KEY_ERS_UNLOCK);
    wr(`FKP_ADDR_ERS_COMMIT, `FKP_KEY_ERS_COMMIT);
  endtask

  task t_erase;
    b = n_erase;
    wr(`FKP_ADDR_ERS_UNLOCK, `FKP_KEY_ERS_UNLOCK);
    rchk("ers set", `FKP_ADDR_ERS_UNLOCK, 32'hFFFF_FFFF, 32'h0000_0001);
    wr(`FKP_ADDR_ERS_UNLOCK, 32'h6666_6667);
    rchk("ers clr", `FKP_ADDR_ERS_UNLOCK, 32'hFFFF_FFFF, 32'h0000_0000);
    wr(`FKP_ADDR_ERS_COMMIT, `FKP_KEY_ERS_COMMIT);
    check("bare commit", n_erase - b, 32'h0000_0000);
    erase(32'h0000_0C00);
    check("ers start", n_erase - b, 32'h0000_0001);
    check("sector", {31'b0, flash_mass_erase}, 32'h0000_0000);
    rchk("ers done clr", `FKP_ADDR_ERS_UNLOCK, 32'hFFFF_FFFF, 32'h0000_0000);
    rchk("commit read", `FKP_ADDR_ERS_COMMIT, 32'hFFFF_FFFF, 32'h0000_0000);
    op_done();
  endtask

  task t_mass;
    rchk("locked", `FKP_ADDR_CTL_UNLOCK, 32'hFFFF_FFFF, 32'h0000_0000);
    apb(1'b1, `FKP_ADDR_CTL_OP, 32'h0001_0000, 4'h4);
    rchk("sel refused", `FKP_ADDR_CTL_OP, 32'h0001_0000, 32'h0000_0000);
    wr(`FKP_ADDR_CTL_UNLOCK, `FKP_KEY_CTL_UNLOCK);
    rchk("unlocked", `FKP_ADDR_CTL_UNLOCK, 32'hFFFF_FFFF, 32'h0000_0001);
    apb(1'b1, `FKP_ADDR_CTL_OP, 32'h0001_0000, 4'h4);
    rchk("sel set", `FKP_ADDR_CTL_OP, 32'h0001_0000, 32'h0001_0000);
    rchk("relocked", `FKP_ADDR_CTL_UNLOCK, 32'hFFFF_FFFF, 32'h0000_0000);
    apb(1'b1, `FKP_ADDR_CTL_OP, 32'h0000_0000, 4'h4);
    rchk("sel kept", `FKP_ADDR_CTL_OP, 32'h0001_0000, 32'h0001_0000);
    b = n_erase;
    erase(32'h0000_0400);
    check("mass start", n_erase - b, 32'h0000_0001);
    check("mass", {31'b0, flash_mass_erase}, 32'h0000_0001);
    op_done();
    wr(`FKP_ADDR_CTL_UNLOCK, `FKP_KEY_CTL_UNLOCK);
    apb(1'b1, `FKP_ADDR_CTL_OP, 32'h0000_0000, 4'h4);
  endtask

  task t_protect;
    wr(`FKP_ADDR_PROT_LO, 32'h0000_0004);
    wr(`FKP_ADDR_PROT_HI, 32'h0000_0001);
    wr(`FKP_ADDR_PROT_KEY, `FKP_KEY_PROT);
    rchk("key bit", `FKP_ADDR_PROT_KEY, 32'hFFFF_FFFF, 32'h0000_0001);
    wr(`FKP_ADDR_PROT_LO, 32'hFFFF_FFFF);
    wr(`FKP_ADDR_PROT_HI, 32'h0000_FFFF);
    rchk("lo locked", `FKP_ADDR_PROT_LO, 32'hFFFF_FFFF, 32'h0000_0004);
    rchk("hi locked", `FKP_ADDR_PROT_HI, 32'hFFFF_FFFF, 32'h0000_0001);
    b = n_prog;
    wr(`FKP_ADDR_TARGET, 32'h0000_0800);
    wr(`FKP_ADDR_PGM_UNLOCK, `FKP_KEY_PGM_UNLOCK);
    wr(`FKP_ADDR_PGM_LAUNCH, `FKP_KEY_PGM_LAUNCH);
    check("kb2 refused", n_prog - b, 32'h0000_0000);
    rchk("viol", `FKP_ADDR_VIOL_STAT, 32'h0100_0000, 32'h0100_0000);
    apb(1'b1, `FKP_ADDR_VIOL_STAT, 32'h0080_0000, 4'h4);
    repeat (2) @(posedge clk);
    check("irq on", {31'b0, violation_irq}, 32'h0000_0001);
    apb(1'b1, `FKP_ADDR_VIOL_STAT, 32'h0100_0000, 4'h8);
    rchk("viol clr", `FKP_ADDR_VIOL_STAT, 32'h0180_0000, 32'h0080_0000);
    check("irq off", {31'b0, violation_irq}, 32'h0000_0000);
    b = n_erase;
    erase(32'h0000_8000);
    check("kb32 refused", n_erase - b, 32'h0000_0000);
    erase(32'h0000_0C00);
    check("kb3 free", n_erase - b, 32'h0000_0001);
    op_done();
    do_reset();
    check("dbg rearmed", {31'b0, debug_port_enable}, 32'h0000_0000);
    rchk("key reset", `FKP_ADDR_PROT_KEY, 32'hFFFF_FFFF, 32'h0000_0000);
    wr(`FKP_ADDR_PROT_LO, 32'h0000_0005);
    rchk("lo open", `FKP_ADDR_PROT_LO, 32'hFFFF_FFFF, 32'h0000_0005);
  endtask

  initial begin
    repeat (30000) @(posedge clk);
    err_count++;
    summarize();
  end

  initial begin
    {nrst, psel, penable, pwrite, flash_done} = 5'b0_0000;
    ce = 1'b1;
    paddr = 32'h0000_0000;
    pwdata = 32'h0000_0000;
    pstrb = 4'h0;
    do_reset();
    t_window();
    t_regs();
    t_debug();
    t_program();
    t_erase();
    t_mass();
    t_protect();
    summarize();
  end
endmodule // testbench
